// ### shared/scr_pkg.sv
package scr_pkg;
    // ==================================================
    // Register word indices (byte address is the index times four)
    localparam logic [3:0]  IDX_FIXED_A   = 4'h2;
    localparam logic [3:0]  IDX_FIXED_B   = 4'h3;
    localparam logic [3:0]  IDX_FIXED_C   = 4'h4;
    localparam logic [3:0]  IDX_REF_IN    = 4'h5;
    localparam logic [3:0]  IDX_REG_DLY   = 4'h6;
    localparam logic [3:0]  IDX_OUT_OVR   = 4'h7;
    localparam logic [3:0]  IDX_VCO_OVR   = 4'h8;
    localparam logic [3:0]  IDX_CTRL      = 4'h0;
    localparam logic [3:0]  IDX_STATUS    = 4'h9;
    // ==================================================
    // Reset values
    localparam logic [15:0] RST_FIXED_A   = 16'h0500;
    localparam logic [15:0] RST_FIXED_B   = 16'h0782;
    localparam logic [15:0] RST_FIXED_C   = 16'h0A43;
    localparam logic [15:0] RST_REF_IN    = 16'h30C8;
    localparam logic [15:0] RST_REG_DLY   = 16'hC802;
    localparam logic [15:0] RST_OUT_OVR   = 16'h00B2;
    localparam logic [15:0] RST_VCO_OVR   = 16'h2000;
    localparam logic [15:0] RST_CTRL      = 16'h0200;
    // ==================================================
    // Field positions
    localparam int          POS_SINGLE_END = 12;
    localparam int          POS_TERM_EN    = 11;
    localparam int          POS_DLY_LO     = 11;
    localparam int          POS_NO_MUTE    = 14;
    localparam int          POS_CUR_OVR    = 14;
    localparam int          POS_CAP_OVR    = 11;
    localparam int          POS_CAL_MUTE   = 9;
    localparam int          POS_SOFT_RST   = 1;
    localparam int          NUM_REGS       = 7;
endpackage : scr_pkg

// ### rtl/scr_config_regs.sv
`timescale 1ns/1ps
module scr_config_regs (
    // Clock and reset
    input  wire  logic        sys_clk,
    input  wire  logic        arst_n,
    // AHB-Lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic       [31:0] hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Calibration engine side
    input  wire  logic        vcoCalibrating,
    input  wire  logic [8:0]  calCurrentSetting,
    input  wire  logic [7:0]  calCapSetting,
    input  wire  logic [8:0]  vcoCurrentSetting,
    input  wire  logic [7:0]  vcoCapSetting,
    // Configuration outputs
    output logic              refSingleEndedSel,
    output logic              refTerminationEn,
    output logic       [4:0]  regulatorStartupDelay,
    output logic              rfOutputFirstMute,
    output logic              rfOutputSecondMute,
    output logic       [8:0]  vcoCurrentApplied,
    output logic       [7:0]  vcoCapApplied
);
    import scr_pkg::*;

    // ==================================================
    // Register storage
    logic [15:0] regs_ff [NUM_REGS];
    logic [15:0] nxt_regs [NUM_REGS];
    logic [15:0] ctrl_ff;
    logic [15:0] nxt_ctrl;
    logic        wrPend_ff;
    logic        nxt_wrPend;
    logic [3:0]  wrIdx_ff;
    logic [3:0]  nxt_wrIdx;
    logic        addrOk_ff;
    logic        nxt_addrOk;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        softRst;
    logic [3:0]  phaseIdx;
    logic        phaseValid;
    logic        phaseAddrOk;

    // Reset values per slot; slot 0 is fixed word A
    function automatic logic [15:0] rstVal(input int i);
        case (i)
            0: rstVal = RST_FIXED_A;
            1: rstVal = RST_FIXED_B;
            2: rstVal = RST_FIXED_C;
            3: rstVal = RST_REF_IN;
            4: rstVal = RST_REG_DLY;
            5: rstVal = RST_OUT_OVR;
            6: rstVal = RST_VCO_OVR;
            default: rstVal = 16'h0000;
        endcase
    endfunction : rstVal

    // ==================================================
    // Address phase decode
    assign phaseIdx    = haddr[5:2];
    assign phaseValid  = hsel && hready && htrans[1];
    assign phaseAddrOk = (haddr[1:0] == 2'h0) && (haddr[31:6] == 26'h0)
                         && ((phaseIdx >= IDX_FIXED_A && phaseIdx <= IDX_VCO_OVR)
                         || phaseIdx == IDX_CTRL || phaseIdx == IDX_STATUS);
    assign softRst     = ctrl_ff[POS_SOFT_RST];

    // Read data is taken in the address phase, so a read issued right after a
    // write to the same word returns the old value; leave one idle cycle between
    // Next state of bus pipeline, registers and read data
    always_comb begin
        nxt_wrPend = phaseValid && hwrite;
        nxt_wrIdx  = phaseIdx;
        nxt_addrOk = phaseAddrOk;
        nxt_ctrl   = ctrl_ff;
        for (int i = 0; i < NUM_REGS; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        // Write data phase, whole 16-bit word
        if (wrPend_ff && addrOk_ff) begin
            if (wrIdx_ff == IDX_CTRL) begin
                nxt_ctrl = hwdata[15:0];
            end else if (wrIdx_ff >= IDX_FIXED_A && wrIdx_ff <= IDX_VCO_OVR) begin
                nxt_regs[3'(wrIdx_ff - IDX_FIXED_A)] = hwdata[15:0];
            end
        end
        // Soft reset restores defaults and clears itself
        if (softRst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                nxt_regs[i] = rstVal(i);
            end
            nxt_ctrl = RST_CTRL;
        end
        // Read data captured at the address phase
        nxt_rdata = 32'h0000_0000;
        if (phaseValid && !hwrite && phaseAddrOk) begin
            if (phaseIdx == IDX_CTRL) begin
                nxt_rdata = {16'h0000, ctrl_ff};
            end else if (phaseIdx == IDX_STATUS) begin
                nxt_rdata = {16'h0000, 5'h00, vcoCapApplied, vcoCurrentApplied[8:6]};
            end else begin
                nxt_rdata = {16'h0000, regs_ff[3'(phaseIdx - IDX_FIXED_A)]};
            end
        end
    end

    // Register update
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= rstVal(i);
            end
            ctrl_ff   <= RST_CTRL;
            wrPend_ff <= 1'b0;
            wrIdx_ff  <= 4'h0;
            addrOk_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
            ctrl_ff   <= nxt_ctrl;
            wrPend_ff <= nxt_wrPend;
            wrIdx_ff  <= nxt_wrIdx;
            addrOk_ff <= nxt_addrOk;
            rdata_ff  <= nxt_rdata;
        end
    end

    // Bus answers: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // ==================================================
    // Configuration decode
    assign refSingleEndedSel     = regs_ff[3][POS_SINGLE_END];
    assign refTerminationEn      = regs_ff[3][POS_TERM_EN];
    assign regulatorStartupDelay = regs_ff[4][15:POS_DLY_LO];

    // Output muting during calibration
    always_comb begin
        rfOutputFirstMute = vcoCalibrating && ctrl_ff[POS_CAL_MUTE]
                            && !regs_ff[5][POS_NO_MUTE];
        rfOutputSecondMute = rfOutputFirstMute;
    end

    // VCO setting selection
    always_comb begin
        vcoCurrentApplied = regs_ff[6][POS_CUR_OVR] ? vcoCurrentSetting
                                                    : calCurrentSetting;
        vcoCapApplied     = regs_ff[6][POS_CAP_OVR] ? vcoCapSetting
                                                    : calCapSetting;
    end

    // ==================================================
    // Assertions
    // Soft reset brings every word back to its default, then the bit drops
    a_soft_rst_defaults: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        softRst |=> (regs_ff[0] == RST_FIXED_A && regs_ff[1] == RST_FIXED_B
                     && regs_ff[2] == RST_FIXED_C))
        else $error("soft reset did not restore fixed words");
    a_soft_rst_others: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        softRst |=> (regs_ff[3] == RST_REF_IN && regs_ff[4] == RST_REG_DLY
                     && regs_ff[5] == RST_OUT_OVR && regs_ff[6] == RST_VCO_OVR
                     && ctrl_ff == RST_CTRL))
        else $error("soft reset did not restore configuration words");
    a_soft_rst_clears: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        softRst |=> !softRst)
        else $error("soft reset bit did not clear");

    // Writes land as whole words, refused writes leave everything alone
    a_write_lands: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_OUT_OVR && !softRst)
        |=> regs_ff[5] == $past(hwdata[15:0]))
        else $error("write did not reach register");
    a_fixed_write_lands: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_FIXED_A && !softRst)
        |=> regs_ff[0] == $past(hwdata[15:0]))
        else $error("write did not reach fixed word");
    a_vco_write_lands: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_VCO_OVR && !softRst)
        |=> regs_ff[6] == $past(hwdata[15:0]))
        else $error("write did not reach override register");
    a_ctrl_write_lands: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_CTRL && !softRst)
        |=> ctrl_ff == $past(hwdata[15:0]))
        else $error("write did not reach control register");
    a_unmapped_write_ignored: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && !addrOk_ff && !softRst)
        |=> ($stable(ctrl_ff) && $stable(regs_ff[0]) && $stable(regs_ff[1])
             && $stable(regs_ff[2]) && $stable(regs_ff[3]) && $stable(regs_ff[4])
             && $stable(regs_ff[5]) && $stable(regs_ff[6])))
        else $error("refused write changed a register");

    // Read data stands for the data phase only and is zero otherwise
    a_read_idle_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !(phaseValid && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_refused_read_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (phaseValid && !hwrite && !phaseAddrOk) |=> hrdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_read_data_value: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (phaseValid && !hwrite && phaseAddrOk && phaseIdx == IDX_REF_IN)
        |=> hrdata[15:0] == $past(regs_ff[3]))
        else $error("read data does not match register");
    a_status_read: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (phaseValid && !hwrite && phaseAddrOk && phaseIdx == IDX_STATUS)
        |=> hrdata[10:3] == $past(vcoCapApplied)
            && hrdata[2:0] == $past(vcoCurrentApplied[8:6]))
        else $error("status read does not match applied settings");

    // Muting during calibration and its no-mute override
    a_mute_follows: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (vcoCalibrating && ctrl_ff[POS_CAL_MUTE] && !regs_ff[5][POS_NO_MUTE])
        |-> (rfOutputFirstMute && rfOutputSecondMute))
        else $error("outputs not muted in calibration");
    a_no_mute_force: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        regs_ff[5][POS_NO_MUTE] |-> !rfOutputFirstMute && !rfOutputSecondMute)
        else $error("outputs muted despite override");
    a_idle_no_mute: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !(vcoCalibrating && ctrl_ff[POS_CAL_MUTE])
        |-> !rfOutputFirstMute && !rfOutputSecondMute)
        else $error("outputs muted outside calibration");

    // VCO current and capacitor come from calibration unless forced
    a_current_select: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !regs_ff[6][POS_CUR_OVR] |-> vcoCurrentApplied == calCurrentSetting)
        else $error("current not from calibration");
    a_current_force: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        regs_ff[6][POS_CUR_OVR] |-> vcoCurrentApplied == vcoCurrentSetting)
        else $error("current override ignored");
    a_cap_select: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        regs_ff[6][POS_CAP_OVR] |-> vcoCapApplied == vcoCapSetting)
        else $error("capacitor override ignored");
    a_cap_calibrated: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !regs_ff[6][POS_CAP_OVR] |-> vcoCapApplied == calCapSetting)
        else $error("capacitor not from calibration");

    // Reference buffer and regulator delay follow their writes
    a_ref_type: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_REF_IN && !softRst)
        |=> refSingleEndedSel == $past(hwdata[12])
            && refTerminationEn == $past(hwdata[11]))
        else $error("reference select did not follow write");
    a_delay_field: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (wrPend_ff && addrOk_ff && wrIdx_ff == IDX_REG_DLY && !softRst)
        |=> regulatorStartupDelay == $past(hwdata[15:11]))
        else $error("delay field did not follow write");

    // Main scenarios reached
    c_soft_reset: cover property (@(posedge sys_clk) disable iff (!arst_n) softRst);
    c_mute: cover property (@(posedge sys_clk) disable iff (!arst_n) rfOutputFirstMute);
    c_cap_ovr: cover property (@(posedge sys_clk) disable iff (!arst_n)
        regs_ff[6][POS_CAP_OVR] && regs_ff[6][POS_CUR_OVR]);
    c_no_mute_cal: cover property (@(posedge sys_clk) disable iff (!arst_n)
        vcoCalibrating && regs_ff[5][POS_NO_MUTE]);
    c_status_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
        phaseValid && !hwrite && phaseAddrOk && phaseIdx == IDX_STATUS);
endmodule : scr_config_regs

// ### sim/test_scr_config_regs.sv
`timescale 1ns/1ps
module test_scr_config_regs;
    import scr_pkg::*;
    // ====================
    // Signals
    logic        sys_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic        vcoCalibrating, selSe, termEn, muteA, muteB;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [8:0]  calCur, setCur, curApplied;
    logic [7:0]  calCap, setCap, capApplied;
    logic [4:0]  dly;
    int          num_errors, cmp_count, cycles;
    localparam logic [3:0]  IDXS [8] = '{IDX_CTRL, IDX_FIXED_A, IDX_FIXED_B, IDX_FIXED_C,
                                         IDX_REF_IN, IDX_REG_DLY, IDX_OUT_OVR, IDX_VCO_OVR};
    localparam logic [15:0] RSTS [8] = '{RST_CTRL, RST_FIXED_A, RST_FIXED_B, RST_FIXED_C,
                                         RST_REF_IN, RST_REG_DLY, RST_OUT_OVR, RST_VCO_OVR};
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    scr_config_regs u_dut (
        .sys_clk (sys_clk), .arst_n (arst_n), .hsel (hsel), .haddr (haddr),
        .htrans (htrans), .hwrite (hwrite), .hsize (hsize), .hwdata (hwdata),
        .hready (hready), .hrdata (hrdata), .hreadyout (hreadyout), .hresp (hresp),
        .vcoCalibrating (vcoCalibrating), .calCurrentSetting (calCur),
        .calCapSetting (calCap), .vcoCurrentSetting (setCur), .vcoCapSetting (setCap),
        .refSingleEndedSel (selSe), .refTerminationEn (termEn),
        .regulatorStartupDelay (dly), .rfOutputFirstMute (muteA),
        .rfOutputSecondMute (muteB), .vcoCurrentApplied (curApplied),
        .vcoCapApplied (capApplied)
    );
    // ====================
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            summarize();
        end
    end
    // ====================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] adr(input logic [3:0] i);
        return {26'h0, i, 2'b00};
    endfunction : adr
    // One single AHB transfer; read data kept in rd
    task automatic busOp(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : busOp
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        busOp(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdChk
    task automatic summarize;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // ====================
    // Scenarios
    task automatic resetValues;
        @(negedge sys_clk);
        chk(selSe, 1'b1);
        chk(termEn, 1'b0);
        chk(dly, 5'h19);
        for (int i = 0; i < 8; i++) begin
            rdChk(adr(IDXS[i]), {16'h0, RSTS[i]});
        end
    endtask : resetValues
    task automatic registerAccess;
        busOp(1'b1, adr(IDX_REF_IN), 32'h28C8);
        @(negedge sys_clk);
        chk(selSe, 1'b0);
        chk(termEn, 1'b1);
        rdChk(adr(IDX_REF_IN), 32'h28C8);
        busOp(1'b1, adr(IDX_REG_DLY), 32'hF802);
        @(negedge sys_clk);
        chk(dly, 5'h1F);
        busOp(1'b1, adr(IDX_REG_DLY), 32'h0802);
        @(negedge sys_clk);
        chk(dly, 5'h01);
        busOp(1'b1, adr(IDX_FIXED_B), 32'hFFFF0782);
        rdChk(adr(IDX_FIXED_B), 32'h0782);
    endtask : registerAccess
    task automatic muteControl;
        @(posedge sys_clk);
        vcoCalibrating <= 1'b1;
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b11);
        busOp(1'b1, adr(IDX_OUT_OVR), 32'h40B2);
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b00);
        busOp(1'b1, adr(IDX_OUT_OVR), 32'h00B2);
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b11);
        busOp(1'b1, adr(IDX_CTRL), 32'h0000);
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b00);
        busOp(1'b1, adr(IDX_CTRL), 32'h0200);
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b11);
        @(posedge sys_clk);
        vcoCalibrating <= 1'b0;
        @(negedge sys_clk);
        chk({muteA, muteB}, 2'b00);
    endtask : muteControl
    task automatic vcoOverride;
        logic [8:0] expCur;
        logic [7:0] expCap;
        for (int k = 0; k < 4; k++) begin
            busOp(1'b1, adr(IDX_VCO_OVR), {16'h0, 1'b0, k[1], 2'b10, k[0], 11'h0});
            expCur = k[1] ? setCur : calCur;
            expCap = k[0] ? setCap : calCap;
            @(negedge sys_clk);
            chk(curApplied, expCur);
            chk(capApplied, expCap);
            rdChk(adr(IDX_STATUS), {21'h0, expCap, expCur[8:6]});
        end
    endtask : vcoOverride
    task automatic softReset;
        busOp(1'b1, adr(IDX_FIXED_A), 32'h0500);
        busOp(1'b1, adr(IDX_FIXED_C), 32'h0A43);
        busOp(1'b1, adr(IDX_OUT_OVR), 32'h40B2);
        busOp(1'b1, adr(IDX_CTRL), {16'h0, RST_CTRL | 16'h0002});
        @(posedge sys_clk);
        resetValues();
    endtask : softReset
    task automatic hardReset;
        busOp(1'b1, adr(IDX_OUT_OVR), 32'h40B2);
        busOp(1'b1, adr(IDX_REF_IN), 32'h28C8);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        resetValues();
    endtask : hardReset
    task automatic unmapped;
        busOp(1'b1, 32'h28, 32'hFFFF);
        rdChk(32'h28, 32'h0);
        busOp(1'b1, 32'h15, 32'h0);
        rdChk(32'h15, 32'h0);
        rdChk(adr(IDX_REF_IN), {16'h0, RST_REF_IN});
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
    endtask : unmapped
    // ====================
    // Main sequence
    initial begin
        {arst_n, hsel, hwrite, vcoCalibrating, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {calCur, calCap, setCur, setCap} = {9'h1A5, 8'h3C, 9'h05A, 8'hC3};
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        resetValues();
        registerAccess();
        muteControl();
        vcoOverride();
        softReset();
        unmapped();
        hardReset();
        summarize();
    end
endmodule : test_scr_config_regs
